// *** hw/fvr_adc_pkg.sv ***
// package: register map, fields and timing for the reference and converter setup block
package fvr_adc_pkg;
  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] REF_CTRL_ADDR  = 8'h00;
  localparam logic [7:0] CONV_CTRL0_ADDR = 8'h04;
  localparam logic [7:0] CONV_CTRL1_ADDR = 8'h08;
  localparam logic [7:0] RES_HIGH_ADDR  = 8'h0C;
  localparam logic [7:0] RES_LOW_ADDR   = 8'h10;
  localparam logic [7:0] STATUS_ADDR    = 8'h14;
  localparam logic [7:0] ANALOG_IN_ADDR = 8'h18;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int REF_EN_BIT    = 7;
  localparam int REF_RDY_BIT   = 6;
  localparam int CDA_GAIN_LSB  = 2;
  localparam int ADC_GAIN_LSB  = 0;
  localparam int CONV_ON_BIT   = 0;
  localparam int GO_BIT        = 1;
  localparam int CHAN_LSB      = 2;
  localparam int PREF_LSB      = 0;
  localparam int DONE_BIT      = 0;
  localparam int WAKE_EN_BIT   = 1;
  // ---------------------------------------------------------------
  // reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [7:0] REF_CTRL_RST  = 8'h00;
  localparam logic [7:0] CONV_CTRL_RST = 8'h00;
  localparam logic [1:0] GAIN_OFF      = 2'h0;
  localparam logic [3:0] CHAN_DAC      = 4'h8;
  localparam logic [3:0] CHAN_FIXREF   = 4'h9;
  localparam logic [1:0] PREF_SUPPLY   = 2'h0;
  localparam logic [1:0] PREF_EXTPIN   = 2'h1;
  localparam logic [1:0] PREF_FIXREF   = 2'h2;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ         = 100;
  localparam int REF_SETTLE_NS   = 1000;
  localparam int REF_SETTLE_CYC  = (REF_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int BIT_TIME_CYC    = 4;
  localparam int RESULT_BITS     = 10;
endpackage

// *** hw/fvr_adc_setup.sv ***
// module: fixed reference control and successive-approximation converter sequencer
`timescale 1ns/1ns
module fvr_adc_setup
  import fvr_adc_pkg::*;
#(
  parameter bit HAS_LDO = 1'b0
)(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // analog side
  input  wire logic        compIn,
  output logic [1:0]       cmpDacGain,
  output logic [1:0]       convRefGain,
  output logic             refPowerOn,
  output logic [3:0]       channelSelect,
  output logic [1:0]       positiveRefSelect,
  output logic [9:0]       dacTrial,
  output logic             sampleHold,
  // events
  output logic             convDone,
  output logic             wakeReq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {IDLE = 2'b00, SAMPLE = 2'b01, CONVERT = 2'b10} conv_t;
  conv_t       state_r;
  conv_t       state_nxt;
  logic [7:0]  refCtrl_r;
  logic [15:0] settle_r;
  logic        refReady_r;
  logic        convOn_r;
  logic        go_r;
  logic [3:0]  chan_r;
  logic [1:0]  pref_r;
  logic [7:0]  analogIn_r;
  logic        done_r;
  logic        wakeEn_r;
  logic [9:0]  sar_r;
  logic [9:0]  result_r;
  logic [3:0]  bitIdx_r;
  logic [7:0]  tick_r;
  logic        cmpSync1_r;
  logic        cmpSync2_r;
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire wrEn     = psel & penable & pwrite;
  wire hitRef   = paddr == REF_CTRL_ADDR;
  wire hitC0    = paddr == CONV_CTRL0_ADDR;
  wire hitC1    = paddr == CONV_CTRL1_ADDR;
  wire hitHi    = paddr == RES_HIGH_ADDR;
  wire hitLo    = paddr == RES_LOW_ADDR;
  wire hitSt    = paddr == STATUS_ADDR;
  wire hitAn    = paddr == ANALOG_IN_ADDR;
  wire mapped   = hitRef | hitC0 | hitC1 | hitHi | hitLo | hitSt | hitAn;
  wire refEn    = refCtrl_r[REF_EN_BIT];
  wire rdyView  = HAS_LDO ? 1'b1 : (refEn & refReady_r);
  wire [7:0] refView = {refEn, rdyView, 2'b00, refCtrl_r[3:0]};
  wire [7:0] c0View  = {2'b00, chan_r, go_r, convOn_r};
  wire [31:0] rdMux =
      hitRef ? {24'h000000, refView} :
      hitC0  ? {24'h000000, c0View} :
      hitC1  ? {30'h00000000, pref_r} :
      hitHi  ? {30'h00000000, result_r[9:8]} :
      hitLo  ? {24'h000000, result_r[7:0]} :
      hitSt  ? {30'h00000000, wakeEn_r, done_r} :
      hitAn  ? {24'h000000, analogIn_r} : 32'h00000000;
  // ---------------------------------------------------------------
  // converter sequencing decode
  // ---------------------------------------------------------------
  wire goWrite   = wrEn & hitC0 & pwdata[GO_BIT] & pwdata[CONV_ON_BIT];
  wire goClear   = wrEn & hitC0 & ~pwdata[GO_BIT];
  wire tickDone  = tick_r == 8'(BIT_TIME_CYC - 1);
  wire lastBit   = bitIdx_r == 4'h0;
  wire finish    = (state_r == CONVERT) & tickDone & lastBit;
  wire abortConv = (state_r != IDLE) & (goClear | ~convOn_r);
  wire [9:0] sarKeep = cmpSync2_r ? sar_r : (sar_r & ~(10'h001 << bitIdx_r));
  wire [9:0] sarNext = lastBit ? sarKeep : (sarKeep | (10'h001 << (bitIdx_r - 4'h1)));
  wire doneSet   = finish;
  wire doneClr   = wrEn & hitSt & pwdata[DONE_BIT];
  wire [1:0] pgain = refEn ? refCtrl_r[3:2] : GAIN_OFF;
  wire [1:0] again = refEn ? refCtrl_r[1:0] : GAIN_OFF;
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      IDLE:    if (goWrite) state_nxt = SAMPLE;
      SAMPLE:  if (abortConv) state_nxt = IDLE;
               else if (tickDone) state_nxt = CONVERT;
      CONVERT: if (abortConv | finish) state_nxt = IDLE;
      default: state_nxt = IDLE;
    endcase
  end
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      refCtrl_r  <= REF_CTRL_RST;
      convOn_r   <= 1'b0;
      chan_r     <= 4'h0;
      pref_r     <= PREF_SUPPLY;
      analogIn_r <= 8'h00;
      wakeEn_r   <= 1'b0;
    end
    else if (wrEn)
    begin
      if (hitRef) refCtrl_r <= {pwdata[7], 3'b000, pwdata[3:0]};
      if (hitC0)
      begin
        convOn_r <= pwdata[CONV_ON_BIT];
        chan_r   <= pwdata[5:2];
      end
      if (hitC1) pref_r <= (pwdata[1:0] == 2'h3) ? PREF_SUPPLY : pwdata[1:0];
      if (hitAn) analogIn_r <= pwdata[7:0];
      if (hitSt) wakeEn_r <= pwdata[WAKE_EN_BIT];
    end
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      settle_r   <= 16'h0000;
      refReady_r <= 1'b0;
    end
    else if (!refEn)
    begin
      settle_r   <= 16'h0000;
      refReady_r <= 1'b0;
    end
    else if (settle_r == 16'(REF_SETTLE_CYC - 1))
      refReady_r <= 1'b1;
    else
      settle_r   <= settle_r + 16'h0001;
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cmpSync1_r <= 1'b0;
      cmpSync2_r <= 1'b0;
    end
    else
    begin
      cmpSync1_r <= compIn;
      cmpSync2_r <= cmpSync1_r;
    end
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r  <= IDLE;
      go_r     <= 1'b0;
      tick_r   <= 8'h00;
      bitIdx_r <= 4'h0;
      sar_r    <= 10'h000;
      result_r <= 10'h000;
      done_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      tick_r  <= (state_r == IDLE || tickDone) ? 8'h00 : tick_r + 8'h01;
      if (goWrite && state_r == IDLE)
      begin
        go_r     <= 1'b1;
        bitIdx_r <= 4'(RESULT_BITS - 1);
        sar_r    <= 10'h200;
      end
      else if (abortConv)
      begin
        go_r     <= 1'b0;
        result_r <= sar_r; // partial result kept on abort
      end
      else if (state_r == CONVERT && tickDone)
      begin
        sar_r <= sarNext;
        if (lastBit)
        begin
          go_r     <= 1'b0;
          result_r <= sarKeep;
        end
        else
          bitIdx_r <= bitIdx_r - 4'h1;
      end
      // set wins over a same-cycle software clear
      done_r <= doneSet | (done_r & ~doneClr);
    end
  end
  // ---------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pready            <= 1'b0;
      prdata            <= 32'h00000000;
      pslverr           <= 1'b0;
      cmpDacGain        <= GAIN_OFF;
      convRefGain       <= GAIN_OFF;
      refPowerOn        <= 1'b0;
      channelSelect     <= 4'h0;
      positiveRefSelect <= PREF_SUPPLY;
      dacTrial          <= 10'h000;
      sampleHold        <= 1'b0;
      convDone          <= 1'b0;
      wakeReq           <= 1'b0;
    end
    else
    begin
      pready            <= psel & ~penable;
      prdata            <= (psel & ~penable & ~pwrite) ? rdMux : prdata;
      pslverr           <= psel & ~penable & ~mapped;
      cmpDacGain        <= pgain;
      convRefGain       <= again;
      refPowerOn        <= refEn;
      channelSelect     <= chan_r;
      positiveRefSelect <= pref_r;
      dacTrial          <= sar_r;
      sampleHold        <= state_r == SAMPLE;
      convDone          <= doneSet;
      wakeReq           <= doneSet & wakeEn_r;
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  ready_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!HAS_LDO && !refEn) |-> !rdyView) else $error("ready flag set while reference off");
  ldo_ready_a: assert property (@(posedge ref_clk) disable iff (rst)
    HAS_LDO |-> rdyView) else $error("ready flag low on regulator variant");
  gain_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    !refEn |=> (cmpDacGain == GAIN_OFF && convRefGain == GAIN_OFF)) else $error("gain on while disabled");
  cda_gain_a: assert property (@(posedge ref_clk) disable iff (rst)
    refEn |=> cmpDacGain == $past(refCtrl_r[3:2])) else $error("comparator gain mismatch");
  done_go_a: assert property (@(posedge ref_clk) disable iff (rst)
    finish |=> (!go_r && done_r && result_r == $past(sarKeep))) else $error("completion effects missing");
  start_go_a: assert property (@(posedge ref_clk) disable iff (rst)
    (goWrite && state_r == IDLE) |=> (go_r && state_r == SAMPLE)) else $error("conversion did not start");
  conv_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == IDLE ##1 state_r == SAMPLE) |-> ##[1:60] (state_r == IDLE)) else $error("conversion too long");
  wake_evt_a: assert property (@(posedge ref_clk) disable iff (rst)
    (finish && wakeEn_r) |=> wakeReq) else $error("no wake on completion");
  chan_route_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wrEn && hitC0) |=> ##1 channelSelect == $past(pwdata[5:2], 2)) else $error("channel not routed");
  conv_done_c: cover property (@(posedge ref_clk) finish);
  abort_c:     cover property (@(posedge ref_clk) abortConv);
  ready_c:     cover property (@(posedge ref_clk) refEn && refReady_r);
endmodule // fvr_adc_setup

// *** tb/tb_top.sv ***
// testbench: register, reference and conversion checks for the setup block
`timescale 1ns/1ns
module tb_top;
  import fvr_adc_pkg::*;
  // ---------------------------------------------------------------
  // signals and design
  // ---------------------------------------------------------------
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, compIn;
  logic        refPowerOn, sampleHold, convDone, wakeReq, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata, ldoPrdata, ldoRdata;
  logic [1:0]  cmpDacGain, convRefGain, positiveRefSelect;
  logic [3:0]  channelSelect;
  logic [9:0]  dacTrial;
  int          mismatches, check_count;

  fvr_adc_setup #(.HAS_LDO(1'b0)) u_fvr_adc_setup (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .compIn(compIn), .cmpDacGain(cmpDacGain), .convRefGain(convRefGain),
    .refPowerOn(refPowerOn), .channelSelect(channelSelect), .positiveRefSelect(positiveRefSelect),
    .dacTrial(dacTrial), .sampleHold(sampleHold), .convDone(convDone), .wakeReq(wakeReq));
  // regulator variant on the same bus: only its read data is watched
  fvr_adc_setup #(.HAS_LDO(1'b1)) u_fvr_adc_setup_ldo (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(ldoPrdata),
    .pslverr(), .compIn(compIn), .cmpDacGain(), .convRefGain(), .refPowerOn(), .channelSelect(),
    .positiveRefSelect(), .dacTrial(), .sampleHold(), .convDone(), .wakeReq());

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until pready is sampled high; bounded so a dead slave cannot hang us
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    ldoRdata = ldoPrdata;
    rerr = pslverr;
    chk({31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // outputs are registered a cycle after the register write lands
  task automatic settle;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask

  // constant comparator input gives an all-ones or all-zeros result
  task automatic conv(input logic c, input logic [3:0] ch, input logic wake);
    int n;
    compIn <= c;
    apb(1'b1, STATUS_ADDR, {30'h0, wake, 1'b0});
    apb(1'b1, CONV_CTRL0_ADDR, {26'h0, ch, 2'b01});
    repeat (4) @(posedge ref_clk);
    apb(1'b1, CONV_CTRL0_ADDR, {26'h0, ch, 2'b11});
    settle();
    chk({31'h0, sampleHold}, 32'h1);
    chk({22'h0, dacTrial}, 32'h200);
    n = 0;
    while (convDone !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk({31'h0, convDone}, 32'h1);
    chk({31'h0, wakeReq}, {31'h0, wake});
    @(posedge ref_clk);
    #1;
    chk({31'h0, convDone}, 32'h0);
    rd(RES_HIGH_ADDR, {30'h0, {2{c}}});
    rd(RES_LOW_ADDR, {24'h0, {8{c}}});
    rd(CONV_CTRL0_ADDR, {26'h0, ch, 2'b01});
    rd(STATUS_ADDR, {30'h0, wake, 1'b1});
    apb(1'b1, STATUS_ADDR, {30'h0, wake, 1'b1});
    rd(STATUS_ADDR, {30'h0, wake, 1'b0});
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    compIn = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd(REF_CTRL_ADDR, 32'h0);
    chk(ldoRdata, 32'h40);
    $display("test reset done");
    for (int g = 0; g < 4; g++)
    begin
      apb(1'b1, REF_CTRL_ADDR, {24'h0, 4'hB, g[1:0], 2'(3 - g)});
      settle();
      chk({30'h0, cmpDacGain}, g);
      chk({30'h0, convRefGain}, 32'(3 - g));
      chk({31'h0, refPowerOn}, 32'h1);
    end
    rd(REF_CTRL_ADDR, 32'h8C);
    repeat (REF_SETTLE_CYC + 5) @(posedge ref_clk);
    rd(REF_CTRL_ADDR, 32'hCC);
    apb(1'b1, REF_CTRL_ADDR, 32'h0F);
    settle();
    chk({28'h0, cmpDacGain, convRefGain}, 32'h0);
    rd(REF_CTRL_ADDR, 32'h0F);
    chk(ldoRdata, 32'h4F);
    $display("test reference done");
    for (int ch = 0; ch < 10; ch++)
    begin
      apb(1'b1, CONV_CTRL0_ADDR, {26'h0, ch[3:0], 2'b00});
      settle();
      chk({28'h0, channelSelect}, ch);
    end
    for (int p = 0; p < 4; p++)
    begin
      apb(1'b1, CONV_CTRL1_ADDR, p);
      settle();
      chk({30'h0, positiveRefSelect}, (p == 3) ? 0 : p);
    end
    $display("test selectors done");
    conv(1'b1, CHAN_FIXREF, 1'b0);
    conv(1'b0, 4'h3, 1'b1);
    $display("test conversion done");
    apb(1'b0, 8'h1C, 32'h0);
    chk(rdata, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, ANALOG_IN_ADDR, 32'hA5);
    rd(ANALOG_IN_ADDR, 32'hA5);
    $display("test map done");
    stop_test();
  end

  // whole run is a few hundred cycles
  initial
  begin
    #200000;
    mismatches++;
    stop_test();
  end
endmodule // tb_top
